// ---- src/amc_ctrl.sv ----
// top: amplifier select, mute, shutdown and sticky fault reporting
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - select low enables bridge amplifier, high enables headphone amplifier
// - only one amplifier active; the other sleeps
// - mute low silences the selected amplifier
// - muted bridge turns on low-side transistors, grounding load
// - shutdown low keeps the whole device shut down
// - code 11 no fault, 10 pump under-voltage, 00 over-temperature
// - under-voltage grounds load; resumes by itself when pump recovers
// - under-voltage code stays until mute, shutdown or power cycles
// - over-temperature grounds load; resumes after temperature falls
// - thermal code stays until mute, shutdown or power cycles
// - thermal protection identical in headphone mode
// - low headphone supply disables headphone amp, no fault code
// - fault lines open-drain; host provides pull-ups
module amc_ctrl
   import amc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        amp_select,
   input  wire logic        mute_n,
   input  wire logic        shutdown_n,
   input  wire logic        pump_undervoltage,
   input  wire logic        over_temp,
   input  wire logic        headphone_supply_low,
   output logic             bridge_enable,
   output logic             headphone_enable,
   output logic             low_side_on,
   output logic             device_shutdown,
   output logic             fault_code_low_o,
   output logic             fault_code_low_oe_n,
   output logic             fault_code_high_o,
   output logic             fault_code_high_oe_n,
   output logic             irq
);
   logic             sel_s;
   logic             mute_s;
   logic             shdn_s;
   logic             uv_s;
   logic             ot_s;
   logic             hps_s;
   logic             sel_eff;
   logic             mute_eff;
   logic             shdn_eff;
   logic             mute_cyc;
   logic             shdn_cyc;
   logic [3:0]       ctrl_q;
   logic [3:0]       ctrl_d;
   logic [2:0]       irq_q;
   logic [2:0]       irq_d;
   logic [2:0]       mask_q;
   logic [2:0]       mask_d;
   logic [2:0]       ev;
   logic             uv_prev_q;
   logic             ot_prev_q;
   logic             hps_prev_q;
   amc_fault_t       fault_q;
   amc_fault_t       fault_d;
   logic [1:0]       code;
   logic             wr_en;
   logic             rd_en;
   logic             known;
   logic [31:0]      rdata_d;
   logic [31:0]      rdata_q;
   logic             lowside_d;
   logic             bridge_d;
   logic             hp_d;
   logic             shdn_d;
   logic [1:0]       code_q;
   logic             lowside_q;
   logic             bridge_q;
   logic             hp_q;
   logic             shdn_q;

   // pins from outside the clock domain pass two flip-flops
   // reset values pick the safe side: shut down, unmuted, supply low
   amc_sync #(.RST_VAL(1'b0)) u_sel (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (amp_select),
      .sync_out (sel_s)
   );
   amc_sync #(.RST_VAL(1'b1)) u_mute (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (mute_n),
      .sync_out (mute_s)
   );
   amc_sync #(.RST_VAL(1'b0)) u_shdn (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (shutdown_n),
      .sync_out (shdn_s)
   );
   amc_sync #(.RST_VAL(1'b0)) u_uv (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (pump_undervoltage),
      .sync_out (uv_s)
   );
   amc_sync #(.RST_VAL(1'b0)) u_ot (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (over_temp),
      .sync_out (ot_s)
   );
   amc_sync #(.RST_VAL(1'b1)) u_hps (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (headphone_supply_low),
      .sync_out (hps_s)
   );

   // control source: pins, or the control register when its source bit is set
   // the register source lets software override the pins at bring-up
   always_comb begin
      if (ctrl_q[AMC_CTRL_SRC_BIT]) begin
         sel_eff  = ctrl_q[AMC_CTRL_SEL_BIT];
         mute_eff = ctrl_q[AMC_CTRL_MUTE_BIT];
         shdn_eff = ctrl_q[AMC_CTRL_SHDN_BIT];
      end else begin
         sel_eff  = sel_s;
         mute_eff = mute_s;
         shdn_eff = shdn_s;
      end
   end

   // a mute or shutdown assert-then-release clears the sticky code
   amc_cycle_det u_mute_cyc (
      .pclk    (pclk),
      .presetn (presetn),
      .level_n (mute_eff),
      .cycled  (mute_cyc)
   );
   amc_cycle_det u_shdn_cyc (
      .pclk    (pclk),
      .presetn (presetn),
      .level_n (shdn_eff),
      .cycled  (shdn_cyc)
   );

   // sticky fault latch; a new fault wins over a clearing cycle
   // under-voltage never overwrites a latched thermal code, which pulls
   // both lines low and must stay visible until the host clears it
   always_comb begin
      fault_d = fault_q;
      if (mute_cyc || shdn_cyc) begin
         fault_d = AMC_F_NONE;
      end
      if (uv_s && fault_q != AMC_F_OT) begin
         fault_d = AMC_F_UV;
      end
      if (ot_s) begin
         fault_d = AMC_F_OT;
      end
   end

   // fault code encoding, thermal dominates
   always_comb begin
      unique case (fault_q)
         AMC_F_UV: code = AMC_CODE_UV;
         AMC_F_OT: code = AMC_CODE_OT;
         default:  code = AMC_CODE_OK;
      endcase
   end

   // amplifier enables and low-side drive from live conditions
   // a muted headphone amp is only disabled; the low side is forced
   // for the bridge alone, whose load would otherwise float
   always_comb begin
      shdn_d    = !shdn_eff;
      // live faults only: recovery is automatic
      lowside_d = !shdn_d && (uv_s || ot_s ||
                  (!mute_eff && !sel_eff));
      bridge_d  = !shdn_d && !sel_eff && mute_eff &&
                  !uv_s && !ot_s;
      hp_d      = !shdn_d && sel_eff && mute_eff &&
                  !ot_s && !hps_s;
   end

   // event detection on rising fault levels
   // previous-level flops reset like their synchronisers, so no false
   // event follows reset
   always_comb begin
      ev = 3'h0;
      ev[AMC_EV_UV]  = uv_s && !uv_prev_q;
      ev[AMC_EV_OT]  = ot_s && !ot_prev_q;
      ev[AMC_EV_HPS] = hps_s && !hps_prev_q;
   end

   // apb decode: zero-wait, every access completes in its access phase
   // reads are taken at the setup edge so prdata stands as a flop output
   always_comb begin
      wr_en = psel && penable && pwrite;
      rd_en = psel && !penable && !pwrite;
      known = (paddr == AMC_CTRL_OFS) || (paddr == AMC_STAT_OFS) ||
              (paddr == AMC_IRQ_OFS) || (paddr == AMC_MASK_OFS);
   end

   // register writes; irq bits are write-one-to-clear, set wins
   // an event in the clearing cycle keeps its bit so it is never lost
   always_comb begin
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      irq_d  = irq_q;
      if (wr_en && paddr == AMC_CTRL_OFS) begin
         ctrl_d = pwdata[3:0];
      end
      if (wr_en && paddr == AMC_MASK_OFS) begin
         mask_d = pwdata[2:0];
      end
      if (wr_en && paddr == AMC_IRQ_OFS) begin
         irq_d = irq_q & ~pwdata[2:0];
      end
      irq_d = irq_d | ev;
   end

   // read data captured in the setup cycle
   always_comb begin
      rdata_d = rdata_q;
      if (rd_en) begin
         rdata_d = AMC_ZERO32;
         unique case (paddr)
            AMC_CTRL_OFS: rdata_d[3:0] = ctrl_q;
            AMC_STAT_OFS: begin
               rdata_d[AMC_ST_BRIDGE_BIT] = bridge_q;
               rdata_d[AMC_ST_HP_BIT]     = hp_q;
               rdata_d[AMC_ST_LOWSIDE]    = lowside_q;
               rdata_d[AMC_ST_SHDN_BIT]   = shdn_q;
               rdata_d[AMC_ST_UV_BIT]     = uv_s;
               rdata_d[AMC_ST_OT_BIT]     = ot_s;
               rdata_d[AMC_ST_CODE_LSB+1:AMC_ST_CODE_LSB] = code_q;
            end
            AMC_IRQ_OFS:  rdata_d[2:0] = irq_q;
            AMC_MASK_OFS: rdata_d[2:0] = mask_q;
            default:      rdata_d = AMC_ZERO32;
         endcase
      end
   end

   // state registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q     <= AMC_CTRL_RST;
         irq_q      <= AMC_IRQ_RST;
         mask_q     <= AMC_IRQ_RST;
         uv_prev_q  <= 1'b0;
         ot_prev_q  <= 1'b0;
         hps_prev_q <= 1'b1;
         fault_q    <= AMC_F_NONE;
         rdata_q    <= AMC_ZERO32;
         code_q     <= AMC_CODE_OK;
         lowside_q  <= 1'b0;
         bridge_q   <= 1'b0;
         hp_q       <= 1'b0;
         shdn_q     <= 1'b1;
      end else begin
         ctrl_q     <= ctrl_d;
         irq_q      <= irq_d;
         mask_q     <= mask_d;
         uv_prev_q  <= uv_s;
         ot_prev_q  <= ot_s;
         hps_prev_q <= hps_s;
         fault_q    <= fault_d;
         rdata_q    <= rdata_d;
         code_q     <= code;
         lowside_q  <= lowside_d;
         bridge_q   <= bridge_d;
         hp_q       <= hp_d;
         shdn_q     <= shdn_d;
      end
   end

   // outputs; fault lines only ever pull low, enable low while driving
   // pready is tied high: no register needs a wait state
   assign prdata               = rdata_q;
   assign pready               = 1'b1;
   assign pslverr              = psel && penable && !known;
   assign bridge_enable        = bridge_q;
   assign headphone_enable     = hp_q;
   assign low_side_on          = lowside_q;
   assign device_shutdown      = shdn_q;
   assign fault_code_low_o     = 1'b0;
   assign fault_code_low_oe_n  = code_q[0];
   assign fault_code_high_o    = 1'b0;
   assign fault_code_high_oe_n = code_q[1];
   assign irq                  = |(irq_q & mask_q);
endmodule : amc_ctrl
`default_nettype wire

// ---- src/amc_cycle_det.sv ----
// detects an active-low assertion followed by its release
`timescale 1ns/100ps
`default_nettype none
module amc_cycle_det (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic level_n,
   output logic      cycled
);
   logic prev_q;
   logic prev_d;
   logic seen_q;
   logic seen_d;
   logic pulse;

   // a low then a high marks one full toggle of the control
   always_comb begin
      prev_d = level_n;
      pulse  = level_n && !prev_q && seen_q;
      seen_d = seen_q;
      if (!level_n) begin
         seen_d = 1'b1;
      end else if (pulse) begin
         seen_d = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= 1'b1;
         seen_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
         seen_q <= seen_d;
      end
   end

   assign cycled = pulse;
endmodule : amc_cycle_det
`default_nettype wire

// ---- src/amc_pkg.sv ----
// package: constants for the amplifier mode, mute and fault control block
package amc_pkg;
   // apb register byte offsets
   localparam logic [7:0] AMC_CTRL_OFS   = 8'h00;
   localparam logic [7:0] AMC_STAT_OFS   = 8'h04;
   localparam logic [7:0] AMC_IRQ_OFS    = 8'h08;
   localparam logic [7:0] AMC_MASK_OFS   = 8'h0C;
   // control register fields
   localparam int AMC_CTRL_SEL_BIT  = 0;
   localparam int AMC_CTRL_MUTE_BIT = 1;
   localparam int AMC_CTRL_SHDN_BIT = 2;
   localparam int AMC_CTRL_SRC_BIT  = 3;
   localparam logic [3:0] AMC_CTRL_RST = 4'h6;
   // status register fields
   localparam int AMC_ST_BRIDGE_BIT = 0;
   localparam int AMC_ST_HP_BIT     = 1;
   localparam int AMC_ST_LOWSIDE    = 2;
   localparam int AMC_ST_SHDN_BIT   = 3;
   localparam int AMC_ST_UV_BIT     = 4;
   localparam int AMC_ST_OT_BIT     = 5;
   localparam int AMC_ST_CODE_LSB   = 6;
   // interrupt event bits
   localparam int AMC_EV_UV  = 0;
   localparam int AMC_EV_OT  = 1;
   localparam int AMC_EV_HPS = 2;
   localparam int AMC_EV_W   = 3;
   localparam logic [2:0] AMC_IRQ_RST = 3'h0;
   // fault codes, bit 1 is the high order line
   localparam logic [1:0] AMC_CODE_OK = 2'h3;
   localparam logic [1:0] AMC_CODE_UV = 2'h2;
   localparam logic [1:0] AMC_CODE_OT = 2'h0;
   localparam logic [31:0] AMC_ZERO32 = 32'h0000_0000;
   // fault latch states
   typedef enum logic [1:0] {AMC_F_NONE, AMC_F_UV, AMC_F_OT} amc_fault_t;
endpackage : amc_pkg

// ---- src/amc_sync.sv ----
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
`default_nettype none
module amc_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   // first stage is read only by the second
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule : amc_sync
`default_nettype wire

// ---- test/amc_ctrl_props.sv ----
// checker: pin-level properties of the amplifier control block
`timescale 1ns/100ps
`default_nettype none
module amc_ctrl_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic amp_select,
   input wire logic mute_n,
   input wire logic shutdown_n,
   input wire logic pump_undervoltage,
   input wire logic over_temp,
   input wire logic headphone_supply_low,
   input wire logic bridge_enable,
   input wire logic headphone_enable,
   input wire logic low_side_on,
   input wire logic device_shutdown,
   input wire logic fault_code_low_oe_n,
   input wire logic fault_code_high_oe_n
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // one mute assertion then a fault-free release
   sequence s_cycle;
      (!mute_n && !pump_undervoltage && !over_temp) ##1
      (mute_n && shutdown_n && !pump_undervoltage && !over_temp)[*5];
   endsequence
   a_one_amp: assert property (
      !(bridge_enable && headphone_enable)) else $error("two amps on");
   a_bridge_on: assert property (
      (!amp_select && mute_n && shutdown_n && !pump_undervoltage
       && !over_temp)[*3] |=> bridge_enable) else $error("bridge off");
   a_mute_ground: assert property (
      (!amp_select && !mute_n && shutdown_n)[*3] |=> low_side_on)
      else $error("muted load not grounded");
   a_shdn_off: assert property (
      (!shutdown_n)[*3] |=> device_shutdown && !bridge_enable
      && !headphone_enable) else $error("shutdown ignored");
   a_uv_ground: assert property (
      (pump_undervoltage && mute_n && shutdown_n)[*5] |=>
      low_side_on && !fault_code_low_oe_n) else $error("uv missed");
   a_ot_code: assert property (
      (over_temp && mute_n && shutdown_n)[*5] |=> low_side_on
      && !fault_code_low_oe_n && !fault_code_high_oe_n)
      else $error("thermal missed");
   a_code_legal: assert property (
      !(fault_code_low_oe_n && !fault_code_high_oe_n))
      else $error("illegal code");
   a_code_sticky: assert property (
      (mute_n && shutdown_n)[*5] ##0 !fault_code_low_oe_n |=>
      !fault_code_low_oe_n) else $error("code dropped");
   a_code_clear: assert property (
      s_cycle |=> fault_code_low_oe_n && fault_code_high_oe_n)
      else $error("code not cleared");
   a_hp_supply: assert property (
      headphone_supply_low[*3] |=> !headphone_enable)
      else $error("headphone on at low supply");
endmodule : amc_ctrl_props
bind amc_ctrl amc_ctrl_props u_props (.pclk, .presetn, .amp_select,
   .mute_n, .shutdown_n, .pump_undervoltage, .over_temp,
   .headphone_supply_low, .bridge_enable, .headphone_enable,
   .low_side_on, .device_shutdown, .fault_code_low_oe_n,
   .fault_code_high_oe_n);
`default_nettype wire

// ---- test/amc_host_mdl.sv ----
// host side model: pull-ups reading the open-drain fault lines
`timescale 1ns/100ps
`default_nettype none
module amc_host_mdl (
   input  wire logic       low_o,
   input  wire logic       low_oe_n,
   input  wire logic       high_o,
   input  wire logic       high_oe_n,
   output logic [1:0]      code
);
   // a released line reads high through its pull-up
   assign code = {high_oe_n ? 1'b1 : high_o,
                  low_oe_n ? 1'b1 : low_o};
endmodule : amc_host_mdl
`default_nettype wire

// ---- test/test_amc_ctrl.sv ----
// testbench: pin and register scenarios for the amplifier control block
`timescale 1ns/100ps
`default_nettype none
module test_amc_ctrl;
   import amc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        amp_select, mute_n, shutdown_n, irq, serr;
   logic        pump_undervoltage, over_temp, headphone_supply_low;
   logic        bridge_enable, headphone_enable, low_side_on;
   logic        device_shutdown, fl_o, fl_oe_n, fh_o, fh_oe_n;
   logic [1:0]  code;
   int          mismatches, checked;
   amc_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .amp_select, .mute_n,
      .shutdown_n, .pump_undervoltage, .over_temp,
      .headphone_supply_low, .bridge_enable, .headphone_enable,
      .low_side_on, .device_shutdown, .fault_code_low_o(fl_o),
      .fault_code_low_oe_n(fl_oe_n), .fault_code_high_o(fh_o),
      .fault_code_high_oe_n(fh_oe_n), .irq);
   amc_host_mdl u_host (.low_o(fl_o), .low_oe_n(fl_oe_n),
      .high_o(fh_o), .high_oe_n(fh_oe_n), .code);
   // 25 MHz clock
   always #20 pclk = ~pclk;
   task automatic end_sim;
      if (mismatches == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string n, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // one apb transfer: setup, then access until pready
   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         mismatches++;
         end_sim();
      end else begin
         rd = prdata;
         serr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb
   task automatic rc(input logic [7:0] a, input logic [31:0] e,
                     input string n);
      apb(a, 1'b0, 32'h0);
      chk(n, e, rd);
   endtask : rc
   task automatic wt;
      repeat (5) @(posedge pclk);
   endtask : wt
   task automatic outs(input logic [3:0] e);
      chk("outs", {28'h0, e}, {28'h0, bridge_enable, headphone_enable,
                               low_side_on, device_shutdown});
   endtask : outs
   task automatic cd(input logic [1:0] e);
      chk("code", {30'h0, e}, {30'h0, code});
   endtask : cd
   // hang guard
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      end_sim();
   end
   initial begin
      {pclk, presetn, psel, penable, pwrite} = 5'h0;
      {pump_undervoltage, over_temp, amp_select} = 3'h0;
      {mute_n, shutdown_n, headphone_supply_low} = 3'h6;
      paddr = 8'h00;
      pwdata = 32'h0;
      mismatches = 0;
      checked = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      cd(AMC_CODE_OK);
      rc(AMC_CTRL_OFS, {28'h0, AMC_CTRL_RST}, "ctrl");
      rc(AMC_IRQ_OFS, 32'h0, "irq_st");
      rc(AMC_MASK_OFS, 32'h0, "mask");
      apb(AMC_CTRL_OFS, 1'b1, 32'hFFFF_FFF7);
      rc(AMC_CTRL_OFS, 32'h7, "ctrl_rw");
      apb(AMC_CTRL_OFS, 1'b1, 32'h6);
      rc(8'h10, 32'h0, "unmapped");
      chk("slverr", 32'h1, {31'h0, serr});
      apb(AMC_MASK_OFS, 1'b1, 32'h7);
      wt();
      outs(4'b1000);
      rc(AMC_STAT_OFS, 32'hC1, "status");
      amp_select <= 1'b1;
      wt();
      outs(4'b0100);
      // register source overrides the pins: bridge, then muted bridge
      apb(AMC_CTRL_OFS, 1'b1, 32'hE);
      wt();
      outs(4'b1000);
      apb(AMC_CTRL_OFS, 1'b1, 32'hC);
      wt();
      outs(4'b0010);
      apb(AMC_CTRL_OFS, 1'b1, 32'h6);
      wt();
      outs(4'b0100);
      mute_n <= 1'b0;
      wt();
      outs(4'b0000);
      amp_select <= 1'b0;
      wt();
      outs(4'b0010);
      mute_n <= 1'b1;
      shutdown_n <= 1'b0;
      wt();
      outs(4'b0001);
      shutdown_n <= 1'b1;
      wt();
      // under-voltage grounds the load, code outlives it
      pump_undervoltage <= 1'b1;
      wt();
      outs(4'b0010);
      cd(AMC_CODE_UV);
      chk("irq", 32'h1, {31'h0, irq});
      pump_undervoltage <= 1'b0;
      wt();
      outs(4'b1000);
      cd(AMC_CODE_UV);
      apb(AMC_IRQ_OFS, 1'b1, 32'h1);
      wt();
      chk("irq_clr", 32'h0, {31'h0, irq});
      mute_n <= 1'b0;
      wt();
      mute_n <= 1'b1;
      wt();
      cd(AMC_CODE_OK);
      // thermal over a pending under-voltage, headphone mode
      amp_select <= 1'b1;
      pump_undervoltage <= 1'b1;
      wt();
      over_temp <= 1'b1;
      wt();
      outs(4'b0010);
      cd(AMC_CODE_OT);
      over_temp <= 1'b0;
      pump_undervoltage <= 1'b0;
      wt();
      outs(4'b0100);
      cd(AMC_CODE_OT);
      rc(AMC_IRQ_OFS, 32'h3, "irq_st");
      apb(AMC_MASK_OFS, 1'b1, 32'h0);
      wt();
      chk("irq_mask", 32'h0, {31'h0, irq});
      apb(AMC_IRQ_OFS, 1'b1, 32'h3);
      rc(AMC_IRQ_OFS, 32'h0, "irq_st");
      shutdown_n <= 1'b0;
      wt();
      shutdown_n <= 1'b1;
      wt();
      cd(AMC_CODE_OK);
      headphone_supply_low <= 1'b1;
      wt();
      outs(4'b0000);
      cd(AMC_CODE_OK);
      rc(AMC_IRQ_OFS, 32'h4, "irq_st");
      headphone_supply_low <= 1'b0;
      wt();
      outs(4'b0100);
      // a reset stands for a power cycle and clears a latched code
      pump_undervoltage <= 1'b1;
      wt();
      cd(AMC_CODE_UV);
      pump_undervoltage <= 1'b0;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      cd(AMC_CODE_OK);
      rc(AMC_IRQ_OFS, 32'h0, "irq_rst");
      wt();
      outs(4'b0100);
      cd(AMC_CODE_OK);
      end_sim();
   end
endmodule : test_amc_ctrl
`default_nettype wire
